// [verilog/serial_port_pkg.sv]
// constants, encodings and helpers shared by the multidrop serial port
package serial_port_pkg;

    // ****************************************************************
    // clocking and timing
    // ****************************************************************
    localparam int CLK_HZ       = 200_000_000;
    localparam int OVERSAMPLE   = 16;
    localparam int DIV_W        = 14;
    localparam int SMP_W        = 4;
    localparam logic [3:0] SMP_MID  = 4'h7;
    localparam logic [3:0] SMP_LAST = 4'hf;
    // end-of-message idle gap in tenths of a character
    localparam int GAP_TENTHS   = 35;
    localparam int GAP_W        = 10;

    // ****************************************************************
    // character frame, buffer and node counts
    // ****************************************************************
    localparam int BUF_DEPTH    = 2047;
    localparam int BUF_IDX_W    = 11;
    localparam logic [5:0] NODES_FOUR_WIRE = 6'h20;
    localparam logic [5:0] NODES_TWO_WIRE  = 6'h1f;

    typedef enum logic [2:0] {
        BAUD_1200  = 3'h0,
        BAUD_2400  = 3'h1,
        BAUD_4800  = 3'h2,
        BAUD_9600  = 3'h3,
        BAUD_19200 = 3'h4,
        BAUD_38400 = 3'h5
    } baud_e;

    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_ODD  = 2'h1,
        PAR_EVEN = 2'h2
    } parity_e;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_START  = 5'b00010,
        ST_DATA   = 5'b00100,
        ST_PARITY = 5'b01000,
        ST_STOP   = 5'b10000
    } line_state_e;

    // clock cycles per oversample tick, rounded to nearest
    function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel);
        int rate;
        case (sel)
            BAUD_1200:  rate = 1200;
            BAUD_2400:  rate = 2400;
            BAUD_4800:  rate = 4800;
            BAUD_19200: rate = 19200;
            BAUD_38400: rate = 38400;
            default:    rate = 9600;
        endcase
        return DIV_W'((CLK_HZ + rate * OVERSAMPLE / 2) / (rate * OVERSAMPLE));
    endfunction

    // bits per character: start, data, optional parity, stop
    function automatic logic [3:0] frame_bits(input logic data8, input logic [1:0] par);
        return 4'(2 + (data8 ? 8 : 7) + ((par == PAR_NONE) ? 0 : 1));
    endfunction

    // oversample ticks in the end-of-message gap
    function automatic logic [GAP_W-1:0] gap_ticks(input logic [3:0] bits);
        return GAP_W'(int'(bits) * OVERSAMPLE * GAP_TENTHS / 10);
    endfunction

endpackage

// [verilog/rx_byte_buffer.sv]
// receive buffer of flip-flops that drops bytes arriving while full
`timescale 1ns/100ps
module rx_byte_buffer
(
    input  wire logic                 mclk_in,
    input  wire logic                 rstn_in,
    input  wire logic                 push_in,
    input  wire logic [7:0]           push_data_in,
    input  wire logic                 pop_in,
    output logic [7:0]                pop_data_out,
    output logic                      not_empty_out,
    output logic                      full_out,
    output logic                      drop_out,
    output logic [serial_port_pkg::BUF_IDX_W-1:0] count_out
);
    import serial_port_pkg::*;

    logic [7:0]           mem_r [BUF_DEPTH];
    logic [BUF_IDX_W-1:0] wr_idx_r;
    logic [BUF_IDX_W-1:0] rd_idx_r;
    logic [BUF_IDX_W-1:0] count_r;
    logic                 do_push;
    logic                 do_pop;

    function automatic logic [BUF_IDX_W-1:0] next_idx(input logic [BUF_IDX_W-1:0] idx);
        return (idx == BUF_IDX_W'(BUF_DEPTH - 1)) ? '0 : idx + 1'b1;
    endfunction

    assign full_out      = (count_r == BUF_IDX_W'(BUF_DEPTH));
    assign not_empty_out = (count_r != '0);
    assign do_pop        = pop_in && not_empty_out;
    // a push into a full buffer is refused; stored bytes are never overwritten
    assign do_push       = push_in && !full_out;
    assign pop_data_out  = mem_r[rd_idx_r];
    assign count_out     = count_r;

    always_ff @(posedge mclk_in) begin
        if (do_push) begin
            mem_r[wr_idx_r] <= push_data_in; // R9
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            count_r  <= '0;
            drop_out <= 1'b0;
        end else begin
            drop_out <= push_in && full_out; // R9
            if (do_push) begin
                wr_idx_r <= next_idx(wr_idx_r);
            end
            if (do_pop) begin
                rd_idx_r <= next_idx(rd_idx_r);
            end
            if (do_push && !do_pop) begin
                count_r <= count_r + 1'b1;
            end else if (do_pop && !do_push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// [verilog/multidrop_serial_port.sv]
// start-stop serial port of a multidrop slave node with receive buffer
//
// Notes on behaviour
// R1 - The bit rate is chosen from 1200, 2400, 4800, 9600, 19200 or 38400 bit/s, same at both ends.
// R2 - Parity is odd, even or absent; the transmitter makes it and the receiver checks it.
// R3 - With four wires the node is one of up to 32 slaves under a single master.
// R4 - Two wires are allowed only with the Modbus slave protocol, with at most 31 slaves.
// R5 - In two-wire mode the host releases its driver within 3.5 characters after its last byte.
// R6 - In two-wire mode the host switches its driver so that the two directions never collide.
// R7 - A character has one start bit, 7 or 8 data bits, optional parity and one stop bit, half-duplex.
// R8 - Bits go out in the order start, data, parity when enabled, then stop.
// R9 - Received bytes go to a 2047-byte buffer and bytes arriving while it is full are dropped.
// R10 - In Modbus RTU an idle gap of at least 3.5 characters ends a message frame.
`timescale 1ns/100ps
module multidrop_serial_port
(
    input  wire logic                 mclk_in,
    input  wire logic                 rstn_in,
    input  wire logic [2:0]           baud_sel_in,
    input  wire logic [1:0]           parity_sel_in,
    input  wire logic                 data8_in,
    input  wire logic                 two_wire_in,
    input  wire logic                 modbus_en_in,
    input  wire logic [5:0]           node_addr_in,
    input  wire logic                 rx_pair_plus_in,
    output logic                      tx_pair_plus_out,
    output logic                      tx_drive_en_out,
    input  wire logic                 tx_valid_in,
    input  wire logic [7:0]           tx_data_in,
    output logic                      tx_ready_out,
    output logic                      rd_valid_out,
    output logic [7:0]                rd_data_out,
    input  wire logic                 rd_ready_in,
    output logic [serial_port_pkg::BUF_IDX_W-1:0] rd_count_out,
    output logic                      rx_parity_err_out,
    output logic                      rx_frame_err_out,
    output logic                      rx_drop_out,
    output logic                      msg_end_out,
    output logic                      wiring_fault_out,
    output logic                      addr_ok_out
);
    import serial_port_pkg::*;

    // ****************************************************************
    // configuration and oversample tick
    // ****************************************************************
    logic [DIV_W-1:0] div_cnt_r;
    logic             tick;
    logic [3:0]       nbits_data;
    logic             par_on;
    logic             link_ok;

    assign nbits_data = data8_in ? 4'h8 : 4'h7; // R7
    assign par_on     = (parity_sel_in != PAR_NONE); // R2
    // two-wire is a wiring fault unless the Modbus slave protocol runs
    assign wiring_fault_out = two_wire_in && !modbus_en_in; // R4
    assign link_ok          = !wiring_fault_out;
    assign addr_ok_out = (node_addr_in != 6'h00) &&
                         (node_addr_in <= (two_wire_in ? NODES_TWO_WIRE
                                                       : NODES_FOUR_WIRE)); // R3 R4

    assign tick = (div_cnt_r == '0);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_cnt_r <= '0;
        end else if (tick) begin
            div_cnt_r <= baud_div(baud_sel_in) - 1'b1; // R1
        end else begin
            div_cnt_r <= div_cnt_r - 1'b1;
        end
    end

    // ****************************************************************
    // receiver
    // ****************************************************************
    logic              rx_meta_r;
    logic              rx_sync_r;
    line_state_e       rx_st_r;
    logic [SMP_W-1:0]  rx_smp_r;
    logic [3:0]        rx_bit_r;
    logic [7:0]        rx_shift_r;
    logic              rx_par_r;
    logic              rx_push_r;
    logic [7:0]        rx_byte_r;
    logic              rx_busy;

    assign rx_busy = (rx_st_r != ST_IDLE);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= rx_pair_plus_in;
            rx_sync_r <= rx_meta_r;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_st_r           <= ST_IDLE;
            rx_smp_r          <= '0;
            rx_bit_r          <= '0;
            rx_shift_r        <= '0;
            rx_par_r          <= 1'b0;
            rx_push_r         <= 1'b0;
            rx_byte_r         <= '0;
            rx_parity_err_out <= 1'b0;
            rx_frame_err_out  <= 1'b0;
        end else begin
            rx_push_r         <= 1'b0;
            rx_parity_err_out <= 1'b0;
            rx_frame_err_out  <= 1'b0;
            if (tick) begin
                rx_smp_r <= rx_smp_r + 1'b1;
                unique case (rx_st_r)
                    ST_IDLE: begin
                        rx_smp_r <= '0;
                        if (!rx_sync_r) begin
                            rx_st_r <= ST_START;
                        end
                    end
                    ST_START: begin
                        // a start bit that is gone at mid-bit was a glitch
                        if (rx_smp_r == SMP_MID) begin
                            rx_smp_r <= '0;
                            rx_bit_r <= '0;
                            rx_st_r  <= rx_sync_r ? ST_IDLE : ST_DATA; // R8
                        end
                    end
                    ST_DATA: begin
                        if (rx_smp_r == SMP_LAST) begin
                            rx_shift_r <= {rx_sync_r, rx_shift_r[7:1]};
                            rx_bit_r   <= rx_bit_r + 1'b1;
                            if (rx_bit_r == nbits_data - 1'b1) begin
                                rx_st_r <= par_on ? ST_PARITY : ST_STOP; // R8
                            end
                        end
                    end
                    ST_PARITY: begin
                        if (rx_smp_r == SMP_LAST) begin
                            rx_par_r <= rx_sync_r;
                            rx_st_r  <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        if (rx_smp_r == SMP_LAST) begin
                            rx_st_r   <= ST_IDLE;
                            rx_push_r <= 1'b1;
                            rx_byte_r <= data8_in ? rx_shift_r : {1'b0, rx_shift_r[7:1]};
                            rx_frame_err_out <= !rx_sync_r; // R7
                            // even: total of ones even; odd: total odd
                            rx_parity_err_out <= par_on &&
                                ((^rx_shift_r ^ (!data8_in && rx_shift_r[0]) ^ rx_par_r)
                                 != (parity_sel_in == PAR_ODD)); // R2
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // end-of-message gap detection
    // ****************************************************************
    logic [GAP_W-1:0] gap_cnt_r;
    logic             gap_armed_r;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gap_cnt_r   <= '0;
            gap_armed_r <= 1'b0;
            msg_end_out <= 1'b0;
        end else begin
            msg_end_out <= 1'b0;
            if (rx_busy || !modbus_en_in) begin
                gap_cnt_r   <= '0;
                gap_armed_r <= rx_busy && modbus_en_in;
            end else if (gap_armed_r && tick) begin
                if (gap_cnt_r >= gap_ticks(frame_bits(data8_in, parity_sel_in)) - 1'b1) begin
                    msg_end_out <= 1'b1; // R10
                    gap_armed_r <= 1'b0;
                    gap_cnt_r   <= '0;
                end else begin
                    gap_cnt_r <= gap_cnt_r + 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // receive buffer
    // ****************************************************************
    rx_byte_buffer rx_byte_buffer_i (
        .mclk_in       (mclk_in),
        .rstn_in       (rstn_in),
        .push_in       (rx_push_r),
        .push_data_in  (rx_byte_r),
        .pop_in        (rd_ready_in),
        .pop_data_out  (rd_data_out),
        .not_empty_out (rd_valid_out),
        .full_out      (),
        .drop_out      (rx_drop_out),
        .count_out     (rd_count_out)
    ); // R9

    // ****************************************************************
    // transmitter
    // ****************************************************************
    line_state_e      tx_st_r;
    logic [SMP_W-1:0] tx_smp_r;
    logic [3:0]       tx_bit_r;
    logic [7:0]       tx_shift_r;
    logic             tx_par_r;

    // half-duplex: a new character is refused while one is arriving
    assign tx_ready_out = (tx_st_r == ST_IDLE) && !rx_busy && link_ok; // R7

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_st_r          <= ST_IDLE;
            tx_smp_r         <= '0;
            tx_bit_r         <= '0;
            tx_shift_r       <= '0;
            tx_par_r         <= 1'b0;
            tx_pair_plus_out <= 1'b1;
            tx_drive_en_out  <= 1'b0;
        end else if (tx_st_r == ST_IDLE) begin
            tx_pair_plus_out <= 1'b1;
            tx_drive_en_out  <= 1'b0;
            if (tx_valid_in && tx_ready_out) begin
                tx_shift_r <= tx_data_in;
                // parity over the bits that are sent only
                tx_par_r   <= (^(data8_in ? tx_data_in : {1'b0, tx_data_in[6:0]}))
                              ^ (parity_sel_in == PAR_ODD); // R2
                tx_smp_r   <= '0;
                tx_st_r    <= ST_START;
                tx_drive_en_out <= 1'b1;
            end
        end else if (tick) begin
            tx_smp_r <= tx_smp_r + 1'b1;
            unique case (tx_st_r)
                ST_START: begin
                    tx_pair_plus_out <= 1'b0; // R8
                    if (tx_smp_r == SMP_LAST) begin
                        tx_bit_r <= '0;
                        tx_st_r  <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    tx_pair_plus_out <= tx_shift_r[0];
                    if (tx_smp_r == SMP_LAST) begin
                        tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                        tx_bit_r   <= tx_bit_r + 1'b1;
                        if (tx_bit_r == nbits_data - 1'b1) begin
                            tx_st_r <= par_on ? ST_PARITY : ST_STOP; // R8
                        end
                    end
                end
                ST_PARITY: begin
                    tx_pair_plus_out <= tx_par_r;
                    if (tx_smp_r == SMP_LAST) begin
                        tx_st_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    tx_pair_plus_out <= 1'b1; // R7
                    // the driver is released one clock after the last tick of ST_STOP, one tick before a full stop bit has passed
                    if (tx_smp_r == SMP_LAST) begin
                        tx_st_r <= ST_IDLE;
                    end
                end
                default: begin
                    tx_st_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// [bench/multidrop_serial_port_monitor.sv]
// concurrent checks on the ports of the multidrop serial port
`timescale 1ns/100ps
module multidrop_serial_port_monitor
    import serial_port_pkg::*;
(
    input  wire logic                 mclk_in,
    input  wire logic                 rstn_in,
    input  wire logic [2:0]           baud_sel_in,
    input  wire logic                 two_wire_in,
    input  wire logic                 modbus_en_in,
    input  wire logic [5:0]           node_addr_in,
    input  wire logic                 tx_pair_plus_out,
    input  wire logic                 tx_drive_en_out,
    input  wire logic                 tx_valid_in,
    input  wire logic                 tx_ready_out,
    input  wire logic                 rd_valid_out,
    input  wire logic [BUF_IDX_W-1:0] rd_count_out,
    input  wire logic                 rx_drop_out,
    input  wire logic                 msg_end_out,
    input  wire logic                 wiring_fault_out,
    input  wire logic                 addr_ok_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // ************************************************************
    // transmit side, wiring fault and node address
    // ************************************************************
    sequence s_take;
        tx_valid_in && tx_ready_out;
    endsequence
    // start bit must follow within one tick, 326 cycles at the top rate
    sequence s_take_fast;
        s_take ##0 baud_sel_in == 3'h5;
    endsequence
    property p_tx_take;
        s_take |=> tx_drive_en_out && !tx_ready_out;
    endproperty
    property p_start_bit;
        s_take_fast |=> tx_pair_plus_out ##[0:330] !tx_pair_plus_out;
    endproperty
    property p_idle_high;
        !tx_drive_en_out |-> tx_pair_plus_out;
    endproperty
    property p_fault;
        wiring_fault_out == (two_wire_in && !modbus_en_in) && !(wiring_fault_out && tx_ready_out);
    endproperty
    property p_addr;
        addr_ok_out == (node_addr_in != 6'h0 && node_addr_in <= (two_wire_in ? 6'h1f : 6'h20));
    endproperty
    // ************************************************************
    // receive side
    // ************************************************************
    property p_drop_full;
        rx_drop_out |-> $past(rd_count_out) == 11'h7ff;
    endproperty
    property p_count_cap;
        rd_count_out <= 11'h7ff && rd_valid_out == (rd_count_out != 11'h0);
    endproperty
    property p_msg_end;
        msg_end_out |-> modbus_en_in && !$past(msg_end_out);
    endproperty
    a_tx_take:   assert property (p_tx_take) else $error("transmit request not taken");
    a_start_bit: assert property (p_start_bit) else $error("start bit late");
    a_idle_high: assert property (p_idle_high) else $error("line not idle high");
    a_fault:     assert property (p_fault) else $error("wiring fault wrong");
    a_addr:      assert property (p_addr) else $error("address range wrong");
    a_drop_full: assert property (p_drop_full) else $error("drop while not full");
    a_count_cap: assert property (p_count_cap) else $error("buffer count wrong");
    a_msg_end:   assert property (p_msg_end) else $error("message end wrong");
endmodule
bind multidrop_serial_port multidrop_serial_port_monitor multidrop_serial_port_monitor_i (
    .mclk_in, .rstn_in, .baud_sel_in, .two_wire_in, .modbus_en_in, .node_addr_in,
    .tx_pair_plus_out, .tx_drive_en_out, .tx_valid_in, .tx_ready_out, .rd_valid_out,
    .rd_count_out, .rx_drop_out, .msg_end_out, .wiring_fault_out, .addr_ok_out);

// [bench/host_link_model.sv]
// host computer model: sends characters to the port and captures replies
`timescale 1ns/100ps
module host_link_model #(
    parameter int BIT_CYC = 5216
) (
    input  wire logic mclk_in,
    input  wire logic line_from_port_in,
    output logic      line_to_port_out
);
    // host driver stays idle high while the port answers, so no collision
    initial line_to_port_out = 1'b1;
    // ************************************************************
    // character sender
    // ************************************************************
    task automatic send_char(input logic [7:0] d, input int n, input logic [1:0] par);
        logic [10:0] f;
        logic        p;
        int          k;
        f = 11'h7ff;
        f[0] = 1'b0;
        p = (par == 2'h1);
        for (int i = 0; i < n; i++) begin
            f[i+1] = d[i];
            p ^= d[i];
        end
        k = n + 1;
        if (par != 2'h0) begin
            f[k] = p;
            k++;
        end
        k++;
        for (int i = 0; i < k; i++) begin
            @(posedge mclk_in);
            #1 line_to_port_out = f[i];
            repeat (BIT_CYC - 1) @(posedge mclk_in);
        end
    endtask
    // ************************************************************
    // character capture, sampling mid-bit
    // ************************************************************
    task automatic recv_char(output logic [15:0] f, input int n);
        f = 16'h0;
        @(negedge line_from_port_in);
        repeat (BIT_CYC / 2) @(posedge mclk_in);
        for (int i = 0; i < n; i++) begin
            f[i] = line_from_port_in;
            repeat (BIT_CYC) @(posedge mclk_in);
        end
    endtask
endmodule

// [bench/multidrop_serial_port_tb.sv]
// self-checking bench of the multidrop serial port against a host model
`timescale 1ns/100ps
module multidrop_serial_port_tb;
    import serial_port_pkg::*;
    localparam int TICK    = (200_000_000 + 307_200) / 614_400;
    localparam int BIT_CYC = 16 * TICK;
    // one received and one sent character at the top rate fit below this
    localparam int LIMIT   = 140000;
    logic                 mclk_in       = 1'b0;
    logic                 rstn_in       = 1'b0;
    logic [2:0]           baud_sel_in   = BAUD_38400;
    logic [1:0]           parity_sel_in = PAR_EVEN;
    logic                 data8_in      = 1'b1;
    logic                 two_wire_in   = 1'b0;
    logic                 modbus_en_in  = 1'b1;
    logic [5:0]           node_addr_in  = 6'h1;
    logic                 rx_line, tx_line, drive_en, tx_ready, rd_valid;
    logic                 tx_valid_in   = 1'b0;
    logic [7:0]           tx_data_in    = 8'h0;
    logic                 rd_ready_in   = 1'b0;
    logic [7:0]           rd_data;
    logic [7:0]           rd_byte;
    logic [BUF_IDX_W-1:0] rd_count;
    logic                 par_err, frm_err, drop, fault, addr_ok, msg_end;
    logic [15:0]          got;
    int                   n_mismatch    = 0;
    int                   n_compared    = 0;
    int                   n_err         = 0;
    int                   n_gap         = 0;
    int                   cyc           = 0;
    int                   addrs[5]      = '{0, 1, 31, 32, 33};
    always #2.5 mclk_in = ~mclk_in;
    multidrop_serial_port multidrop_serial_port_i (
        .mclk_in, .rstn_in, .baud_sel_in, .parity_sel_in, .data8_in, .two_wire_in,
        .modbus_en_in, .node_addr_in, .rx_pair_plus_in(rx_line), .tx_pair_plus_out(tx_line),
        .tx_drive_en_out(drive_en), .tx_valid_in, .tx_data_in, .tx_ready_out(tx_ready),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data), .rd_ready_in,
        .rd_count_out(rd_count), .rx_parity_err_out(par_err), .rx_frame_err_out(frm_err),
        .rx_drop_out(drop), .msg_end_out(msg_end), .wiring_fault_out(fault),
        .addr_ok_out(addr_ok));
    host_link_model #(.BIT_CYC(BIT_CYC)) host_link_model_i (
        .mclk_in, .line_from_port_in(tx_line), .line_to_port_out(rx_line));
    // ************************************************************
    // checking and closing
    // ************************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic step();
        @(posedge mclk_in);
        #1;
    endtask
    task automatic write_tx(input logic [7:0] d);
        tx_data_in  = d;
        tx_valid_in = 1'b1;
        // hold the request through the edge at which ready is seen high
        while (tx_ready !== 1'b1)
            step();
        step();
        tx_valid_in = 1'b0;
    endtask
    task automatic read_rx(output logic [7:0] d);
        d           = rd_data;
        rd_ready_in = 1'b1;
        step();
        rd_ready_in = 1'b0;
    endtask
    always @(posedge mclk_in) begin
        cyc++;
        if (par_err === 1'b1 || frm_err === 1'b1 || drop === 1'b1)
            n_err++;
        if (msg_end === 1'b1)
            n_gap++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            give_verdict();
        end
    end
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (10) @(posedge mclk_in);
        #1 rstn_in = 1'b1;
        step();
        chk("rd_count", 16'h0, 16'(rd_count));
        chk("tx_line", 16'h1, 16'(tx_line));
        for (int w = 0; w < 2; w++) begin
            foreach (addrs[i]) begin
                two_wire_in = w[0];
                node_addr_in = 6'(addrs[i]);
                step();
                chk("addr_ok", 16'(addrs[i] > 0 && addrs[i] <= 32 - w), 16'(addr_ok));
            end
        end
        modbus_en_in = 1'b0;
        step();
        chk("fault", 16'h1, 16'(fault));
        chk("tx_ready", 16'h0, 16'(tx_ready));
        modbus_en_in = 1'b1;
        two_wire_in = 1'b0;
        step();
        chk("tx_ready", 16'h1, 16'(tx_ready));
        fork
            host_link_model_i.send_char(8'ha7, 8, PAR_EVEN);
            begin
                repeat (3 * BIT_CYC) step();
                chk("tx_ready_busy", 16'h0, 16'(tx_ready));
            end
        join
        for (int i = 0; i < BIT_CYC && rd_valid !== 1'b1; i++)
            step();
        chk("rd_count", 16'h1, 16'(rd_count));
        chk("rx_errors", 16'h0, 16'(n_err));
        read_rx(rd_byte);
        chk("rd_data", 16'ha7, 16'(rd_byte));
        chk("rd_valid", 16'h0, 16'(rd_valid));
        data8_in = 1'b0;
        parity_sel_in = PAR_ODD;
        fork
            host_link_model_i.recv_char(got, 10);
            write_tx(8'hc5);
        join
        chk("tx_frame", {6'h0, 1'b1, ~^7'h45, 7'h45, 1'b0}, got);
        for (int i = 0; i < BIT_CYC && drive_en === 1'b1; i++)
            step();
        chk("drive_en", 16'h0, 16'(drive_en));
        chk("tx_idle", 16'h1, 16'(tx_line));
        // far less than 3.5 characters of idle have passed since the last byte
        chk("msg_end", 16'h0, 16'(n_gap));
        give_verdict();
    end
endmodule
